// ### src/cfsm_pkg.sv
// Shared constants and types for the camera fault status monitor
package cfsm_pkg;

	// ==========================================================
	// Register offsets (byte addresses on the bus)
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_RESET = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;

	// ==========================================================
	// Status word field positions
	localparam int ST_OVERVOLT_BIT = 6;
	localparam int ST_OVERTEMP_BIT = 20;
	localparam int ST_HOT_NOW_BIT = 21;
	localparam int ST_SUPPLY_OFF_BIT = 22;

	// ==========================================================
	// Reset request field and control fields
	localparam int RST_FIELD_LSB = 0;
	localparam int RST_FIELD_W = 8;
	localparam logic [7:0] RESET_KEY = 8'h5A;
	localparam int CTRL_TEST_BIT = 0;
	localparam int CTRL_LIVE_BIT = 1;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0002;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int RST_PULSE_NS = 1000;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LED_HALF_MS = 250;
	localparam int LED_HALF_CYC = LED_HALF_MS * (CLK_HZ / 1000);

	// ==========================================================
	// Over-temperature state
	typedef enum logic [1:0] {
		TS_COOL = 2'b01,
		TS_HOT = 2'b10
	} cfsm_temp_t;

endpackage : cfsm_pkg

// ### src/cfsm_sync.sv
// Two-stage synchroniser bank for asynchronous comparator levels
`timescale 1ns/1ps
`default_nettype none

module cfsm_sync #(
	parameter int W = 5
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	// ==========================================================
	// One pair of flops per comparator; first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic stage1;
			logic stage2;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else if (ce_i) begin
					stage1 <= async_i[g];
					stage2 <= stage1;
				end
			end
			assign sync_o[g] = stage2;
		end
	endgenerate

endmodule : cfsm_sync

`default_nettype wire

// ### src/cfsm_flash.sv
// Red LED flasher: while enabled, lit for HALF_CYC-1 cycles then dark for one; dark otherwise
`timescale 1ns/1ps
`default_nettype none

module cfsm_flash #(
	parameter int HALF_CYC = cfsm_pkg::LED_HALF_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Control and LED
	input wire logic en_i,
	output logic led_o
);

	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] cnt;
	wire logic wrap = (cnt == LAST);

	// ==========================================================
	// Restart phase on each enable so the first flash is a full lit phase of HALF_CYC-1 cycles
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
			led_o <= 1'b0;
		end else if (ce_i) begin
			if (!en_i) begin
				cnt <= '0;
				led_o <= 1'b0;
			end else begin
				cnt <= wrap ? '0 : cnt + 1'b1;
				if (wrap || !led_o && cnt == '0)
					led_o <= wrap ? !led_o : 1'b1;
			end
		end
	end

endmodule : cfsm_flash

`default_nettype wire

// ### src/cfsm_top.sv
// Camera fault status monitor: temperature and supply faults, status word, reset
`timescale 1ns/1ps
`default_nettype none

module cfsm_top #(
	parameter int LED_HALF_CYC = cfsm_pkg::LED_HALF_CYC,
	parameter logic [7:0] RESET_KEY = cfsm_pkg::RESET_KEY
) (
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	// Wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Comparator levels (asynchronous)
	input wire logic TEMP_HI_I,
	input wire logic TEMP_LO_I,
	input wire logic OV_BAND_I,
	input wire logic OV_HIGH_I,
	input wire logic UV_I,
	// Camera controls
	output logic SENSOR_EN_O,
	output logic LIVE_EN_O,
	output logic TEST_IMG_O,
	output logic LED_RED_O,
	output logic REG_EN_O,
	output logic CAM_RESET_O
);

	// ==========================================================
	// Synchronised comparator levels
	logic [4:0] cmp_s;
	wire logic t_hi = cmp_s[0];
	wire logic t_lo = cmp_s[1];
	wire logic ov_s = cmp_s[2];
	wire logic ovh_s = cmp_s[3];
	wire logic uv_s = cmp_s[4];

	// Raw levels pass through two flops first
	cfsm_sync #(.W(5)) u_sync (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.async_i({UV_I, OV_HIGH_I, OV_BAND_I, TEMP_LO_I, TEMP_HI_I}),
		.sync_o(cmp_s)
	);

	// ==========================================================
	// Bus decode
	wire logic bus_req = CYC_I && STB_I && !ACK_O;
	wire logic bus_wr = bus_req && WE_I && SEL_I[0];
	wire logic hit_status = (ADR_I == cfsm_pkg::ADR_STATUS);
	wire logic hit_reset = (ADR_I == cfsm_pkg::ADR_RESET);
	wire logic hit_ctrl = (ADR_I == cfsm_pkg::ADR_CTRL);
	wire logic wr_key = bus_wr && hit_reset &&
		DAT_I[cfsm_pkg::RST_FIELD_LSB +: cfsm_pkg::RST_FIELD_W] == RESET_KEY;
	wire logic wr_ctrl = bus_wr && hit_ctrl;

	// ==========================================================
	// Soft reset sequencer
	localparam int RCW = $clog2(cfsm_pkg::RST_PULSE_CYC + 1);
	localparam logic [RCW-1:0] RST_LOAD = RCW'(cfsm_pkg::RST_PULSE_CYC);
	logic [RCW-1:0] rst_cnt;
	// Clearing pulse fires as the camera reset pulse ends
	wire logic soft_clr = CE_I && (rst_cnt == RCW'(1));

	// Pulse length counter; a key write during a pulse restarts it
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_cnt <= '0;
			CAM_RESET_O <= 1'b0;
		end else if (CE_I) begin
			if (wr_key) begin
				rst_cnt <= RST_LOAD;
				CAM_RESET_O <= 1'b1;
			end else if (rst_cnt != '0) begin
				rst_cnt <= rst_cnt - 1'b1;
				CAM_RESET_O <= (rst_cnt != RCW'(1));
			end
		end
	end

	// ==========================================================
	// Over-temperature state with hysteresis
	cfsm_pkg::cfsm_temp_t tstate;
	cfsm_pkg::cfsm_temp_t next_tstate;

	// Hysteresis band between thresholds holds the current state
	always_comb begin
		next_tstate = tstate;
		unique case (tstate)
			cfsm_pkg::TS_COOL: begin
				if (t_hi)
					next_tstate = cfsm_pkg::TS_HOT;
			end
			cfsm_pkg::TS_HOT: begin
				if (t_lo)
					next_tstate = cfsm_pkg::TS_COOL;
			end
			default: next_tstate = cfsm_pkg::TS_COOL;
		endcase
	end

	// Soft reset does not cool the sensor, so the state survives it
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			tstate <= cfsm_pkg::TS_COOL;
		else if (CE_I)
			tstate <= next_tstate;
	end

	// ==========================================================
	// Status flags
	logic ot_sticky;
	logic ov_err;
	wire logic hot_now = (tstate == cfsm_pkg::TS_HOT);
	wire logic supply_off = uv_s || ovh_s;

	// Detection wins over a reset that lands in the same cycle
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ot_sticky <= 1'b0;
			ov_err <= 1'b0;
		end else if (CE_I) begin
			if (next_tstate == cfsm_pkg::TS_HOT)
				ot_sticky <= 1'b1;
			else if (soft_clr)
				ot_sticky <= 1'b0;
			ov_err <= ov_s;
		end
	end

	// ==========================================================
	// Control register: test image request and live enable
	logic [31:0] ctrl;

	// Returns to default at the end of a soft reset, like a power cycle
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			ctrl <= cfsm_pkg::CTRL_RESET_VAL;
		else if (CE_I) begin
			if (soft_clr)
				ctrl <= cfsm_pkg::CTRL_RESET_VAL;
			else if (wr_ctrl)
				ctrl <= {30'h0000_0000, DAT_I[cfsm_pkg::CTRL_LIVE_BIT],
					DAT_I[cfsm_pkg::CTRL_TEST_BIT]};
		end
	end

	// ==========================================================
	// Status word assembled from live state every cycle
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[cfsm_pkg::ST_OVERVOLT_BIT] = ov_err;
		status_word[cfsm_pkg::ST_OVERTEMP_BIT] = ot_sticky;
		status_word[cfsm_pkg::ST_HOT_NOW_BIT] = hot_now;
		status_word[cfsm_pkg::ST_SUPPLY_OFF_BIT] = supply_off;
	end

	// Unmapped offsets read zero and are still acknowledged
	wire logic [31:0] rd_mux = hit_status ? status_word :
		hit_ctrl ? ctrl : 32'h0000_0000;

	// ==========================================================
	// Bus answer: one wait state, ack for one cycle; never gated by faults
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else if (CE_I) begin
			ACK_O <= bus_req;
			if (bus_req)
				DAT_O <= WE_I ? 32'h0000_0000 : rd_mux;
		end
	end

	// ==========================================================
	// Sensor and image gating; decided from the next state to save a cycle
	wire logic next_cool = (next_tstate == cfsm_pkg::TS_COOL);
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SENSOR_EN_O <= 1'b0;
			LIVE_EN_O <= 1'b0;
			TEST_IMG_O <= 1'b0;
			REG_EN_O <= 1'b0;
		end else if (CE_I) begin
			SENSOR_EN_O <= next_cool && !supply_off;
			LIVE_EN_O <= next_cool && !supply_off && ctrl[cfsm_pkg::CTRL_LIVE_BIT];
			TEST_IMG_O <= !supply_off && ctrl[cfsm_pkg::CTRL_TEST_BIT];
			REG_EN_O <= !supply_off;
		end
	end

	// ==========================================================
	// LED flasher driven by the overvoltage flag
	cfsm_flash #(.HALF_CYC(LED_HALF_CYC)) u_flash (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.en_i(ov_err),
		.led_o(LED_RED_O)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	logic rd_status_q;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			rd_status_q <= 1'b0;
		else if (CE_I && bus_req)
			rd_status_q <= !WE_I && hit_status;
	end

	sequence s_key_taken;
		CE_I && wr_key;
	endsequence

	sequence s_pulse_runs;
		CAM_RESET_O ##1 CAM_RESET_O;
	endsequence

	// Only the onset: later in a fault the LED may be in its one dark cycle
	sequence s_ov_seen;
		CE_I && ov_s && !ov_err ##1 CE_I;
	endsequence

	AST_HOT_ENTRY: assert property (CE_I && !hot_now && t_hi |=> hot_now && !SENSOR_EN_O)
		else $error("sensor not switched off on over-temperature");

	AST_HOT_EXIT: assert property (CE_I && hot_now && t_lo |=> !hot_now)
		else $error("over-temperature did not clear below lower threshold");

	AST_HOT_HOLD: assert property (CE_I && hot_now && !t_lo |=> hot_now && !SENSOR_EN_O)
		else $error("sensor resumed inside hysteresis band");

	AST_NO_LIVE: assert property (hot_now |-> !LIVE_EN_O)
		else $error("live images enabled while hot");

	AST_OT_BIT: assert property (ACK_O && rd_status_q |-> DAT_O[20] == $past(ot_sticky))
		else $error("status bit 20 does not show over-temperature flag");

	AST_OT_STICKY: assert property (ot_sticky && !soft_clr |=> ot_sticky)
		else $error("over-temperature bit dropped without reset");

	AST_OV_LED: assert property (s_ov_seen |=> ##[0:1] LED_RED_O)
		else $error("LED not lit after overvoltage");

	AST_OV_OFF: assert property (CE_I && !ov_err |=> !LED_RED_O)
		else $error("LED still flashing with supply normal");

	AST_OV_BIT: assert property (ACK_O && rd_status_q |-> DAT_O[6] == $past(ov_err))
		else $error("status bit 6 does not show overvoltage flag");

	AST_OV_TRACK: assert property (CE_I |=> ov_err == $past(ov_s))
		else $error("overvoltage flag does not track supply");

	AST_UV_OFF: assert property (CE_I && uv_s |=> !REG_EN_O && !SENSOR_EN_O)
		else $error("operation continues under undervoltage");

	AST_OVH_OFF: assert property (CE_I && ovh_s |=> !REG_EN_O)
		else $error("operation continues under high overvoltage");

	AST_RESET_PULSE: assert property (s_key_taken |=> s_pulse_runs)
		else $error("reset key did not start reset pulse");

	AST_SYNC_DELAY: assert property ($past(CE_I) && $past(CE_I, 2) |-> t_hi == $past(TEMP_HI_I, 2))
		else $error("temperature level not delayed by two flops");

endmodule : cfsm_top

`default_nettype wire

// ### tb/cfsm_host.sv
// Host model: classic single-cycle bus master for status and control access
`timescale 1ns/1ps
`default_nettype none

module cfsm_host (
	// Clock
	input wire logic clk_i,
	// Bus master side
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	// ==========================================================
	// Idle bus at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end

	// ==========================================================
	// One transfer; held until ack; only the bench watchdog ends a dead wait
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		@(posedge clk_i);
		while (ack_i !== 1'b1) begin
			@(posedge clk_i);
		end
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		@(posedge clk_i);
	endtask : xfer

	// Reset request carries the key in the low byte lane
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		xfer(1'b1, a, d, s, q);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
	endtask : rd
endmodule : cfsm_host

`default_nettype wire

// ### tb/cfsm_top_tb.sv
// Self-checking bench for the camera fault status monitor
`timescale 1ns/1ps
`default_nettype none

module cfsm_top_tb;
	// ==========================================================
	// Clock, reset and stimulus
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic t_hi = 1'b0, t_lo = 1'b1, ov_b = 1'b0, ov_h = 1'b0, uv = 1'b0;
	logic cyc, stb, we, ack, sen, live, tst, led, reg_en, cam_rst;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	int n_mismatch = 0;
	int tests_run = 0;
	always #12.5 clk = ~clk;

	// Short LED period keeps the flashing visible in a short run
	cfsm_top #(.LED_HALF_CYC(4)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
		.DAT_O(rdat), .ACK_O(ack), .TEMP_HI_I(t_hi), .TEMP_LO_I(t_lo), .OV_BAND_I(ov_b),
		.OV_HIGH_I(ov_h), .UV_I(uv), .SENSOR_EN_O(sen), .LIVE_EN_O(live),
		.TEST_IMG_O(tst), .LED_RED_O(led), .REG_EN_O(reg_en), .CAM_RESET_O(cam_rst));
	cfsm_host u_host (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	// ==========================================================
	// Shared helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(posedge clk);
	endtask : step

	task stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	// ==========================================================
	// Scenario: values after power-on, unmapped and write-only reads
	task t_reset;
		u_host.rd(8'h00, q);
		chk("status", q, 32'h0000_0000);
		u_host.rd(8'h08, q);
		chk("ctrl", q, 32'h0000_0002);
		u_host.rd(8'h04, q);
		chk("reset rd", q, 32'h0000_0000);
		u_host.rd(8'h0C, q);
		chk("unmapped", q, 32'h0000_0000);
		chk("sensor", sen, 1'b1);
		chk("live", live, 1'b1);
		chk("regulator", reg_en, 1'b1);
		chk("led", led, 1'b0);
	endtask : t_reset

	// Scenario: heat, hysteresis, sticky bit, bad keys then good key
	task t_hot;
		int n;
		@(posedge clk);
		t_hi <= 1'b1;
		t_lo <= 1'b0;
		step(1);
		chk("sync delay", sen, 1'b1);
		step(4);
		chk("sensor hot", sen, 1'b0);
		chk("live hot", live, 1'b0);
		u_host.rd(8'h00, q);
		chk("status hot", q, 32'h0030_0000);
		u_host.wr(8'h08, 32'h0000_0003, 4'hF);
		chk("test img", tst, 1'b1);
		chk("live hot", live, 1'b0);
		@(posedge clk);
		t_hi <= 1'b0;
		step(6);
		chk("sensor mid", sen, 1'b0);
		t_lo <= 1'b1;
		step(6);
		chk("sensor cool", sen, 1'b1);
		chk("live cool", live, 1'b1);
		u_host.rd(8'h00, q);
		chk("sticky", q, 32'h0010_0000);
		u_host.wr(8'h04, 32'h0000_005B, 4'hF);
		chk("bad key", cam_rst, 1'b0);
		u_host.wr(8'h04, 32'h0000_005A, 4'h0);
		chk("lane off", cam_rst, 1'b0);
		u_host.wr(8'h04, 32'h0000_005A, 4'h1);
		chk("reset on", cam_rst, 1'b1);
		for (n = 0; n < 60 && cam_rst !== 1'b0; n++) begin
			step(1);
		end
		chk("reset off", cam_rst, 1'b0);
		u_host.rd(8'h00, q);
		chk("sticky clr", q, 32'h0000_0000);
		u_host.rd(8'h08, q);
		chk("ctrl back", q, 32'h0000_0002);
	endtask : t_hot

	// Scenario: overvoltage band flashes LED, bit self-clears
	task t_ov;
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		@(posedge clk);
		ov_b <= 1'b1;
		step(5);
		u_host.rd(8'h00, q);
		chk("ov bit", q, 32'h0000_0040);
		repeat (20) begin
			@(posedge clk);
			if (led === 1'b1)
				hi++;
			if (led === 1'b0)
				lo++;
		end
		chk("flashing", (hi > 0 && lo > 0), 1'b1);
		ov_b <= 1'b0;
		step(6);
		chk("led dark", led, 1'b0);
		u_host.rd(8'h00, q);
		chk("ov clr", q, 32'h0000_0000);
	endtask : t_ov

	// Scenario: undervoltage and high overvoltage cut the regulator
	task t_supply;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			uv <= (k == 0);
			ov_h <= (k == 1);
			step(5);
			chk("reg off", reg_en, 1'b0);
			u_host.rd(8'h00, q);
			chk("supply bit", q, 32'h0040_0000);
			uv <= 1'b0;
			ov_h <= 1'b0;
			step(6);
			chk("reg on", reg_en, 1'b1);
		end
	endtask : t_supply

	// Scenario: enable low freezes the synchronisers, so a fault waits for it
	task t_freeze;
		@(posedge clk);
		ce <= 1'b0;
		uv <= 1'b1;
		step(6);
		chk("frozen reg", reg_en, 1'b1);
		ce <= 1'b1;
		step(5);
		chk("thawed reg", reg_en, 1'b0);
		uv <= 1'b0;
		step(6);
		chk("reg back", reg_en, 1'b1);
	endtask : t_freeze

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		step(16);
		rst_n <= 1'b1;
		step(2);
		t_reset;
		t_hot;
		t_ov;
		t_supply;
		t_freeze;
		// No serial link here, so there is no stray character to flush
		stop_test;
	end

	initial begin
		step(5000);
		n_mismatch++;
		stop_test;
	end
endmodule : cfsm_top_tb

`default_nettype wire
